// >>> cbmfe_bench.sv
// Self-checking bench of the card bus mode front end
`include "cbmfe_cfg.svh"
`timescale 1ns/1ns
module card_bus_mode_front_end_bench;
   logic       clk, rst_b, bus_clk, cmd_h, data_h, sel_b, cmd_w, data_w;
   logic       cmd_o, cmd_oe, data_o, data_oe, spi_mode, card_sel, rx_valid;
   logic [7:0] rx_byte;
   logic       rxd_valid, rxd_bit, cmd_reject, tx_valid, tx_ready;
   logic [7:0] tx_byte;
   logic       tx_on_data, fast_cmd, prog_busy, rx_on;
   logic [7:0] rxq[$];
   logic       dbits[$];
   logic [5:0] idxs[6] = '{`CBMFE_IDX_BCAST, `CBMFE_IDX_SRD, `CBMFE_IDX_MRD,
                           `CBMFE_IDX_SWR, `CBMFE_IDX_MWR, 6'h11};
   int         error_cnt, checks, rej_cnt, k;

   cbmfe_top dut
   (
      .CLK(clk), .RST_B(rst_b), .BUS_CLK(bus_clk), .CMD_I(cmd_w), .CMD_O(cmd_o),
      .CMD_OE(cmd_oe), .CARD_DATA_LINE_I(data_w), .CARD_DATA_LINE_O(data_o),
      .CARD_DATA_LINE_OE(data_oe),
      .RESERVED_PAD_I(sel_b), .SPI_MODE(spi_mode), .CARD_SELECTED(card_sel),
      .RX_VALID(rx_valid), .RX_BYTE(rx_byte), .RX_DATA_BIT_VALID(rxd_valid),
      .RX_DATA_BIT(rxd_bit), .CMD_REJECT(cmd_reject), .TX_VALID(tx_valid),
      .TX_READY(tx_ready), .TX_BYTE(tx_byte), .TX_ON_DATA(tx_on_data),
      .FAST_CMD(fast_cmd), .PROG_BUSY(prog_busy)
   );

   cbmfe_host_model host
   (
      .bus_clk(bus_clk), .cmd_h(cmd_h), .data_h(data_h), .sel_b(sel_b),
      .cmd_w(cmd_w), .data_w(data_w), .cmd_oe(cmd_oe), .data_oe(data_oe)
   );

   // Released lines fall back to the pull-up level held by the host
   assign cmd_w  = cmd_oe ? cmd_o : cmd_h;
   assign data_w = data_oe ? data_o : data_h;

   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_int(input int got, input int exp);
      checks++;
      if (got != exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
      end
   endtask : chk_int

   task automatic test_done;
      if (error_cnt == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done

   function automatic logic [47:0] frame(input logic [5:0] idx);
      frame = {2'b01, idx, 32'($urandom), 7'($urandom), 1'b1};
   endfunction : frame

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask : wait_clk

   // Two bus clock rises after reset release the link side
   task automatic do_reset;
      rst_b <= 1'b0;
      wait_clk(5);
      rst_b <= 1'b1;
      wait_clk(4);
      repeat (2) host.tick();
      wait_clk(1);
   endtask : do_reset

   task automatic cmd0(input logic sel);
      host.sel_b <= sel;
      wait_clk(8);
      host.send({`CBMFE_CMD0_BYTE, 32'h0000_0000, 8'h95});
      wait_clk(10);
   endtask : cmd0

   task automatic native_rx;
      logic [47:0] f;
      f = frame(6'(1 + $urandom % 63));
      rxq.delete();
      dbits.delete();
      host.dq.delete();
      rx_on = 1'b1;
      host.send(f);
      wait_clk(10);
      rx_on = 1'b0;
      chk_int(rxq.size(), 6);
      for (k = 0; k < rxq.size() && k < 6; k++)
         chk_byte(rxq[k], f[47-8*k -: 8]);
      chk_int(dbits.size(), 48);
      for (k = 0; k < dbits.size() && k < 48; k++)
         chk_bit(dbits[k], host.dq[k]);
   endtask : native_rx

   // Leaves the strobe up so that back-to-back offers need no gap
   task automatic push(input logic [7:0] b);
      tx_byte  <= b;
      tx_valid <= 1'b1;
      @(negedge clk);
      while (tx_ready !== 1'b1)
         @(negedge clk);
      @(posedge clk);
   endtask : push

   // Mode 0: data pad, 1: command pad push-pull, 2: command pad open-drain
   task automatic tx_run(input int m);
      logic [7:0] b[3];
      int         j;
      for (j = 0; j < 3; j++)
         b[j] = 8'($urandom);
      tx_on_data <= (m == 0);
      fast_cmd   <= (m != 2);
      host.watch_cmd = (m != 0);
      wait_clk(2);
      host.got_w.delete();
      host.got_oe.delete();
      push(b[0]);
      push(b[1]);
      tx_byte <= b[2];
      @(negedge clk);
      chk_bit(tx_ready, 1'b0);
      @(posedge clk);
      fork
         begin
            push(b[2]);
            tx_valid <= 1'b0;
         end
         repeat (26) host.tick();
      join
      for (j = 0; j < 24; j++)
      begin
         chk_bit(host.got_w[j], b[j/8][7-j%8]);
         chk_bit(host.got_oe[j], (m == 2) ? ~b[j/8][7-j%8] : 1'b1);
      end
   endtask : tx_run

   task automatic spi_cmd(input logic [5:0] idx, input int rej);
      int r0;
      r0 = rej_cnt;
      rxq.delete();
      host.send(frame(idx));
      wait_clk(10);
      chk_int(rej_cnt - r0, rej);
      chk_int(rxq.size(), 6);
   endtask : spi_cmd

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      if (rx_valid === 1'b1)
         rxq.push_back(rx_byte);
      if (rxd_valid === 1'b1 && rx_on)
         dbits.push_back(rxd_bit);
      if (cmd_reject === 1'b1)
         rej_cnt++;
      if (spi_mode === 1'b1)
         chk_bit(cmd_oe, 1'b0);
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      test_done();
   end

   initial
   begin
      {clk, rst_b, tx_valid, rx_on, prog_busy} = 5'h00;
      {tx_on_data, fast_cmd} = 2'h3;
      tx_byte = 8'h00;
      void'($urandom(32'h7d5a_8a11));
      do_reset();
      chk_bit(spi_mode, 1'b0);
      chk_bit(card_sel, 1'b1);
      chk_bit(data_oe, 1'b0);
      native_rx();
      native_rx();
      cmd0(1'b1);
      chk_bit(spi_mode, 1'b0);
      cmd0(1'b0);
      chk_bit(spi_mode, 1'b0);
      for (k = 0; k < 3; k++)
         tx_run(k);
      do_reset();
      chk_bit(spi_mode, 1'b0);
      cmd0(1'b0);
      chk_bit(spi_mode, 1'b1);
      chk_bit(data_oe, 1'b1);
      prog_busy <= 1'b1;
      wait_clk(3);
      chk_bit(data_o, 1'b0);
      host.sel_b <= 1'b1;
      wait_clk(6);
      chk_bit(card_sel, 1'b0);
      chk_bit(data_oe, 1'b0);
      host.sel_b <= 1'b0;
      wait_clk(6);
      chk_bit(data_o, 1'b0);
      prog_busy <= 1'b0;
      wait_clk(3);
      chk_bit(data_o, 1'b1);
      for (int i = 0; i < 6; i++)
         spi_cmd(idxs[i], (i < 5) ? 1 : 0);
      host.sel_b <= 1'b1;
      wait_clk(6);
      rxq.delete();
      host.send(frame(6'h11));
      wait_clk(10);
      chk_int(rxq.size(), 0);
      test_done();
   end

endmodule : card_bus_mode_front_end_bench

// >>> cbmfe_buf2.sv
// Two-entry valid/ready buffer
`timescale 1ns/1ns
module cbmfe_buf2
#(
   parameter int W = 8
)
(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);

   logic [W-1:0] mem_r [2];
   logic         wp_r;
   logic         rp_r;
   logic [1:0]   cnt_r;
   logic         push;
   logic         pop;

   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         wp_r     <= 1'b0;
         rp_r     <= 1'b0;
         cnt_r    <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            mem_r[wp_r] <= in_data;
            wp_r        <= ~wp_r;
         end
         if (pop)
            rp_r <= ~rp_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : cbmfe_buf2

// >>> cbmfe_cfg.svh
// Constants of the card bus mode front end
`ifndef CBMFE_CFG_SVH
`define CBMFE_CFG_SVH

// First byte of the reset command: start 0, direction 1, index 0
`define CBMFE_CMD0_BYTE    8'h40
// Bit index of the last bit of a 48-bit command frame
`define CBMFE_FRAME_LAST   6'h2f
// Command index field of the first byte
`define CBMFE_IDX_MSB      5
// Command indexes refused in SPI mode
`define CBMFE_IDX_BCAST    6'h02
`define CBMFE_IDX_SRD      6'h0b
`define CBMFE_IDX_MRD      6'h12
`define CBMFE_IDX_SWR      6'h14
`define CBMFE_IDX_MWR      6'h19
// Bus clock limit; the bit handshake needs three core clocks per bus half
`define CBMFE_BUS_MAX_MHZ  20
// Bits per transmitted byte
`define CBMFE_BYTE_BITS    4'h8

`endif

// >>> cbmfe_host_model.sv
// Host side model: bus clock, command frames, chip select and pad sampling
`timescale 1ns/1ns
module cbmfe_host_model
#(
   parameter int HALF = 30
)
(
   output logic      bus_clk,
   output logic      cmd_h,
   output logic      data_h,
   output logic      sel_b,
   input  wire logic cmd_w,
   input  wire logic data_w,
   input  wire logic cmd_oe,
   input  wire logic data_oe
);
   logic watch_cmd;
   logic dq[$];
   logic got_w[$];
   logic got_oe[$];

   initial
   begin
      bus_clk   = 1'b0;
      cmd_h     = 1'b1;
      data_h    = 1'b1;
      sel_b     = 1'b1;
      watch_cmd = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clock stands low between frames; the 60 ns period keeps the bus under its limit
   task automatic tick;
      #HALF bus_clk = 1'b1;
      #HALF bus_clk = 1'b0;
   endtask : tick

   // Command bits change only while the clock is low; select is held by the caller
   task automatic send(input logic [47:0] f);
      int i;
      for (i = 47; i >= 0; i--)
      begin
         cmd_h  = f[i];
         data_h = 1'($urandom);
         dq.push_back(data_h);
         tick();
      end
      cmd_h  = 1'b1;
      data_h = 1'b1;
   endtask : send

   ////////////////////////////////////////////////////////////////////////////////
   // Device bits are taken half a period after the rise, when they have settled
   always @(negedge bus_clk)
   begin
      got_w.push_back(watch_cmd ? cmd_w : data_w);
      got_oe.push_back(watch_cmd ? cmd_oe : data_oe);
   end

endmodule : cbmfe_host_model

// >>> cbmfe_pkg.sv
// Types of the card bus mode front end
package cbmfe_pkg;

   typedef enum logic {MODE_NATIVE, MODE_SPI} cbmfe_mode_type;

   typedef enum logic {RX_IDLE, RX_FRAME} cbmfe_rx_type;

endpackage : cbmfe_pkg

// >>> cbmfe_sync2.sv
// Two-flop level synchroniser
`timescale 1ns/1ns
module cbmfe_sync2
#(
   parameter int W = 1
)
(
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : cbmfe_sync2

// >>> cbmfe_top.sv
// Card bus mode front end: mode select, pad roles and bit transport
`include "cbmfe_cfg.svh"
`timescale 1ns/1ns
module cbmfe_top
   import cbmfe_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       RST_B,
   input  wire logic       BUS_CLK,
   input  wire logic       CMD_I,
   output      logic       CMD_O,
   output      logic       CMD_OE,
   input  wire logic       CARD_DATA_LINE_I,
   output      logic       CARD_DATA_LINE_O,
   output      logic       CARD_DATA_LINE_OE,
   input  wire logic       RESERVED_PAD_I,
   output      logic       SPI_MODE,
   output      logic       CARD_SELECTED,
   output      logic       RX_VALID,
   output      logic [7:0] RX_BYTE,
   output      logic       RX_DATA_BIT_VALID,
   output      logic       RX_DATA_BIT,
   output      logic       CMD_REJECT,
   input  wire logic       TX_VALID,
   output      logic       TX_READY,
   input  wire logic [7:0] TX_BYTE,
   input  wire logic       TX_ON_DATA,
   input  wire logic       FAST_CMD,
   input  wire logic       PROG_BUSY
);

   ////////////////////////////////////////////////////////////////////
   // Link side, on the host's bus clock

   logic [1:0] lrst_r;
   logic       link_rst_b;
   logic       bit_tgl_r;
   logic [2:0] lbits_r;

   // Reset released on bus clock; RST_B is the power-on detector
   always_ff @(posedge BUS_CLK or negedge RST_B)
   begin
      if (!RST_B)
         lrst_r <= 2'h0;
      else
         lrst_r <= {lrst_r[0], 1'b1};
   end
   assign link_rst_b = lrst_r[1];

   // Held for a whole bus period, read by the core after the toggle
   always_ff @(posedge BUS_CLK or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         bit_tgl_r <= 1'b0;
         lbits_r   <= 3'h7;
      end
      else
      begin
         bit_tgl_r <= ~bit_tgl_r;
         lbits_r   <= {RESERVED_PAD_I, CARD_DATA_LINE_I, CMD_I};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Crossing into the core clock

   logic [1:0] sync_q;
   logic       tgl_seen_r;
   logic       bit_evt;
   logic       cs_high_s;
   logic       cmd_b;
   logic       cdl_b;
   logic       cs_b;

   cbmfe_sync2 #(.W(2)) u_sync
   (
      .clk   (CLK),
      .rst_b (RST_B),
      .d     ({RESERVED_PAD_I, bit_tgl_r}),
      .q     (sync_q)
   );

   // A stopped bus clock simply yields no events
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         tgl_seen_r <= 1'b0;
      else
         tgl_seen_r <= sync_q[0];
   end
   assign bit_evt   = sync_q[0] ^ tgl_seen_r;
   assign cs_high_s = sync_q[1];
   assign cmd_b     = lbits_r[0];
   assign cdl_b     = lbits_r[1];
   assign cs_b      = lbits_r[2];

   ////////////////////////////////////////////////////////////////////
   // Mode select

   cbmfe_mode_type mode_r;
   logic           mode_lock_r;
   logic           is_spi;
   logic           byte_done;
   logic           first_byte;
   logic           cs_all_low_r;
   logic [7:0]     rx_sh_r;
   logic [7:0]     rx_byte_nxt;
   logic           got_cmd0;

   assign is_spi   = (mode_r == MODE_SPI);
   assign got_cmd0 = byte_done && first_byte && (rx_byte_nxt == `CBMFE_CMD0_BYTE);

   // First reset command decides, until the next power-on
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         mode_r      <= MODE_NATIVE;
         mode_lock_r <= 1'b0;
      end
      else if (got_cmd0 && !mode_lock_r)
      begin
         mode_lock_r <= 1'b1;
         mode_r      <= (cs_all_low_r && !cs_b) ? MODE_SPI : MODE_NATIVE;
      end
   end

   assign SPI_MODE      = is_spi;
   assign CARD_SELECTED = !is_spi || !cs_high_s;

   ////////////////////////////////////////////////////////////////////
   // Command receive

   cbmfe_rx_type rx_st_r;
   logic [5:0]   rx_cnt_r;
   logic         rx_gate;
   logic [5:0]   idx;
   logic         idx_bad;

   // In SPI mode a deselected card hears nothing
   assign rx_gate     = !is_spi || !cs_b;
   assign rx_byte_nxt = {rx_sh_r[6:0], cmd_b};
   assign byte_done   = bit_evt && (rx_st_r == RX_FRAME) && rx_gate
                        && (rx_cnt_r[2:0] == 3'h7);
   assign first_byte  = (rx_cnt_r[5:3] == 3'h0);
   assign idx         = rx_byte_nxt[`CBMFE_IDX_MSB:0];
   assign idx_bad     = (idx == `CBMFE_IDX_BCAST) || (idx == `CBMFE_IDX_SRD)
                        || (idx == `CBMFE_IDX_MRD) || (idx == `CBMFE_IDX_SWR)
                        || (idx == `CBMFE_IDX_MWR);

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rx_st_r      <= RX_IDLE;
         rx_cnt_r     <= 6'h00;
         rx_sh_r      <= 8'h00;
         cs_all_low_r <= 1'b0;
      end
      else if (bit_evt)
      begin
         case (rx_st_r)
            RX_IDLE:
            begin
               // Start bit on the command line opens a frame
               if (!cmd_b && rx_gate)
               begin
                  rx_st_r      <= RX_FRAME;
                  rx_cnt_r     <= 6'h01;
                  rx_sh_r      <= {7'h00, cmd_b};
                  cs_all_low_r <= !cs_b;
               end
            end
            RX_FRAME:
            begin
               if (!rx_gate)
                  rx_st_r <= RX_IDLE;
               else
               begin
                  rx_sh_r      <= rx_byte_nxt;
                  rx_cnt_r     <= rx_cnt_r + 6'h01;
                  cs_all_low_r <= cs_all_low_r && !cs_b;
                  if (rx_cnt_r == `CBMFE_FRAME_LAST)
                     rx_st_r <= RX_IDLE;
               end
            end
            default:
               rx_st_r <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         RX_VALID   <= 1'b0;
         RX_BYTE    <= 8'h00;
         CMD_REJECT <= 1'b0;
      end
      else
      begin
         RX_VALID   <= byte_done;
         CMD_REJECT <= byte_done && first_byte && is_spi && idx_bad;
         if (byte_done)
            RX_BYTE <= rx_byte_nxt;
      end
   end

   // Native data line bits go up one per bus clock
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         RX_DATA_BIT_VALID <= 1'b0;
         RX_DATA_BIT       <= 1'b0;
      end
      else
      begin
         RX_DATA_BIT_VALID <= bit_evt && !is_spi && !CARD_DATA_LINE_OE;
         if (bit_evt)
            RX_DATA_BIT <= cdl_b;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transmit path

   logic       tb_valid;
   logic [7:0] tb_data;
   logic       tb_pop;
   logic [7:0] tx_sh_r;
   logic [3:0] tx_left_r;
   logic       tx_bit_r;
   logic       tx_act_r;
   logic       tx_cdl_r;
   logic       tx_allow;

   // Buffer drains only on bus clocks, so a stopped clock fills it
   cbmfe_buf2 #(.W(8)) u_txbuf
   (
      .clk       (CLK),
      .rst_b     (RST_B),
      .in_valid  (TX_VALID),
      .in_ready  (TX_READY),
      .in_data   (TX_BYTE),
      .out_valid (tb_valid),
      .out_ready (tb_pop),
      .out_data  (tb_data)
   );

   assign tx_allow = !is_spi || !cs_high_s;
   assign tb_pop   = bit_evt && (tx_left_r == 4'h0) && tb_valid && tx_allow;

   // Bit changes just after the host's rising edge, sampled on the following fall
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         tx_sh_r   <= 8'h00;
         tx_left_r <= 4'h0;
         tx_bit_r  <= 1'b1;
         tx_act_r  <= 1'b0;
         tx_cdl_r  <= 1'b0;
      end
      else if (bit_evt)
      begin
         if (tx_left_r != 4'h0)
         begin
            tx_bit_r  <= tx_sh_r[7];
            tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
            tx_left_r <= tx_left_r - 4'h1;
            tx_act_r  <= 1'b1;
         end
         else if (tb_pop)
         begin
            tx_bit_r  <= tb_data[7];
            tx_sh_r   <= {tb_data[6:0], 1'b0};
            tx_left_r <= `CBMFE_BYTE_BITS - 4'h1;
            tx_act_r  <= 1'b1;
            tx_cdl_r  <= TX_ON_DATA || is_spi;
         end
         else
            tx_act_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pad drive

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         CMD_O  <= 1'b0;
         CMD_OE <= 1'b0;
      end
      else if (is_spi || !tx_act_r || tx_cdl_r)
      begin
         CMD_O  <= 1'b0;
         CMD_OE <= 1'b0;
      end
      else if (FAST_CMD)
      begin
         CMD_O  <= tx_bit_r;
         CMD_OE <= 1'b1;
      end
      else
      begin
         CMD_O  <= 1'b0;
         CMD_OE <= !tx_bit_r;
      end
   end

   // Busy is held low on data out whenever selected in SPI mode and not sending, even after reselect
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         CARD_DATA_LINE_O  <= 1'b1;
         CARD_DATA_LINE_OE <= 1'b0;
      end
      else if (is_spi)
      begin
         CARD_DATA_LINE_OE <= !cs_high_s;
         CARD_DATA_LINE_O  <= (tx_act_r) ? tx_bit_r : !PROG_BUSY;
      end
      else
      begin
         CARD_DATA_LINE_OE <= tx_act_r && tx_cdl_r;
         CARD_DATA_LINE_O  <= tx_bit_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   a_mode_default: assert property (@(posedge CLK) disable iff (!RST_B)
      !mode_lock_r |-> mode_r == MODE_NATIVE)
      else $error("mode left native without reset command");

   a_mode_held: assert property (@(posedge CLK) disable iff (!RST_B)
      mode_lock_r |=> $stable(mode_r) && mode_lock_r)
      else $error("latched mode changed");

   a_spi_entry: assert property (@(posedge CLK) disable iff (!RST_B)
      $rose(mode_r == MODE_SPI) |-> $past(got_cmd0 && !cs_b && cs_all_low_r))
      else $error("SPI entered without select low on reset command");

   a_one_bit: assert property (@(posedge CLK) disable iff (!RST_B)
      tx_left_r != $past(tx_left_r) |-> $past(bit_evt))
      else $error("transmit bit moved without bus clock");

   a_cmd_opendrain: assert property (@(posedge CLK) disable iff (!RST_B)
      CMD_OE && CMD_O |-> $past(FAST_CMD) && !$past(is_spi))
      else $error("command line driven high while open-drain");

   a_spi_cmd_in: assert property (@(posedge CLK) disable iff (!RST_B)
      is_spi ##1 is_spi |-> !CMD_OE)
      else $error("command pad driven in SPI mode");

   a_spi_select: assert property (@(posedge CLK) disable iff (!RST_B)
      RX_VALID && is_spi && $past(is_spi) |-> $past(!cs_b))
      else $error("byte taken while deselected");

   a_reject_spi: assert property (@(posedge CLK) disable iff (!RST_B)
      CMD_REJECT |-> is_spi && RX_VALID)
      else $error("reject outside SPI mode");

   a_busy_hold: assert property (@(posedge CLK) disable iff (!RST_B)
      is_spi && !cs_high_s && !tx_act_r && PROG_BUSY
      |=> CARD_DATA_LINE_OE && !CARD_DATA_LINE_O)
      else $error("busy not shown on data out");

   a_spi_release: assert property (@(posedge CLK) disable iff (!RST_B)
      is_spi && cs_high_s |=> !CARD_DATA_LINE_OE)
      else $error("data out driven while deselected");

endmodule : cbmfe_top
